// ### core/bus_error_code_reporter.sv
// bus error code reporter: runs one programming message and posts its outcome
// assumes an APB master on ref_clk, bus line states from pins, a transfer
// engine and serial error code on ref_clk
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bus_error_map.svh"

//
// Behaviour
// - failure flag implies a posted error code
// - failure flag bit 15, set on error
// - code 0 when no bus error
// - code 1: controller role needed, absent
// - code 2: write with no listener
// - code 2: ATN asserted during write
// - code 3: transfer while not addressed
// - code 3: shadow standby with ATN off
// - code 4: bad argument, timeout range
// - interface-clear duration out of range
// - address 31, bad termination, bad poll
// - bad argument discards whole message
// - code 5: clear/remote without system control
// - system controller after power-on
// - code 6: transfer cancelled or timed out
// - code 11: function from other mode
// - code 17: unrecognised function name
module bus_error_code_reporter import bus_error_pkg::*; #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // bus line states, asynchronous
    input  wire logic        cicPin,
    input  wire logic        atnPin,
    input  wire logic        talkPin,
    input  wire logic        listenPin,
    input  wire logic        listenersPin,
    // transfer engine
    output logic             ioStart,
    output logic             ioWrite,
    output logic             ioCancel,
    input  wire logic        ioDone,
    input  wire logic        ioAbort,
    // controller actions
    output logic             ifcStart,
    output logic             renOn,
    output logic             shadowStart,
    // serial side error code
    input  wire logic [2:0]  serialCode
);
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("TICK_CYCLES must lie in 1..65535");
    end

    state_e      state;
    logic [4:0]  pinMeta;
    logic [4:0]  pinSync;
    logic        cic;
    logic        atn;
    logic        talk;
    logic        listen;
    logic        listeners;
    logic [8:0]  funcReg;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic        cfgMode;
    logic        sysCtrl;
    logic [31:0] tmoReg;
    logic [4:0]  ownAddr;
    code_t       pendCode;
    code_t       busCode;
    logic [2:0]  serialPosted;
    logic        failFlag;
    logic [15:0] tickCnt;
    logic [31:0] unitCnt;
    logic        timedOut;
    func_t       funcId;
    logic        shadowReq;
    logic        known;
    logic        modeWrong;
    logic        isIo;
    code_t       verdict;
    logic        apbDone;
    logic        apbWrite;
    logic        launch;
    logic        next_pslverr;
    logic [31:0] next_prdata;
    logic [31:0] statusWord;

    arg_check_if chk ();
    arg_range_checker u_chk (
        .chk (chk.judge)
    );
    assign chk.funcId = funcId;
    assign chk.arg0   = arg0;
    assign chk.arg1   = arg1;

    // ************************************
    // pin synchronisers
    // ************************************
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinMeta <= 5'h00;
            pinSync <= 5'h00;
        end else begin
            pinMeta <= {listenersPin, listenPin, talkPin, atnPin, cicPin};
            pinSync <= pinMeta;
        end
    end
    assign cic       = pinSync[0];
    assign atn       = pinSync[1];
    assign talk      = pinSync[2];
    assign listen    = pinSync[3];
    assign listeners = pinSync[4];

    // ************************************
    // apb slave, one wait state
    // ************************************
    assign apbDone  = psel & penable & pready;
    assign apbWrite = apbDone & pwrite & ~pslverr;
    assign launch   = apbWrite && paddr == `REG_FUNC;

    always_comb begin
        statusWord                   = 32'h0000_0000;
        statusWord[`STAT_BUSY_BIT]   = state != IDLE;
        statusWord[`STAT_FAIL_BIT]   = failFlag;
        statusWord[`STAT_CMPL_BIT]   = 1'b1;
        statusWord[`STAT_CIC_BIT]    = cic;
        statusWord[`STAT_ATN_BIT]    = atn;
        statusWord[`STAT_TALK_BIT]   = talk;
        statusWord[`STAT_LISTEN_BIT] = listen;
    end

    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (paddr)
            `REG_FUNC: begin
                next_prdata  = {23'h000000, funcReg};
                // a new message while one runs would tear the outcome
                next_pslverr = pwrite && state != IDLE;
            end
            `REG_ARG0: begin
                next_prdata  = arg0;
                next_pslverr = pwrite && state != IDLE;
            end
            `REG_ARG1: begin
                next_prdata  = arg1;
                next_pslverr = pwrite && state != IDLE;
            end
            `REG_CONFIG: begin
                next_prdata[`CFG_MODE_BIT] = cfgMode;
                next_prdata[`CFG_SC_BIT]   = sysCtrl;
                next_prdata[`CFG_ADDR_LSB +: 5] = ownAddr;
            end
            `REG_STATUS: begin
                next_prdata  = statusWord;
                next_pslverr = pwrite;
            end
            `REG_ERROR: begin
                next_prdata = {21'h000000, serialPosted, 3'h0, busCode};
                next_pslverr = pwrite;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_pslverr;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            funcReg <= 9'h000;
            arg0    <= 32'h0000_0000;
            arg1    <= 32'h0000_0000;
        end else if (apbWrite) begin
            if (paddr == `REG_FUNC) begin
                funcReg <= pwdata[8:0];
            end
            if (paddr == `REG_ARG0) begin
                arg0 <= pwdata;
            end
            if (paddr == `REG_ARG1) begin
                arg1 <= pwdata;
            end
        end
    end

    // ************************************
    // message decode and verdict
    // ************************************
    assign funcId    = funcReg[4:0];
    assign shadowReq = funcReg[`FUNC_SHADOW_BIT];
    assign known     = (funcId >= `F_WRITE && funcId <= `F_RSC) || funcId == `F_GSTAT;
    assign modeWrong = funcId[4] != cfgMode;
    assign isIo      = funcId == `F_WRITE || funcId == `F_READ;

    always_comb begin
        verdict = `NO_BUS_FAULT_CODE;
        if (!known) begin
            verdict = `UNKNOWN_FUNCTION_CODE;
        end else if (modeWrong) begin
            verdict = `WRONG_MODE_CODE;
        end else if (chk.argBad) begin
            verdict = `BAD_ARGUMENT_CODE;
        end else if ((funcId == `F_SIC || funcId == `F_SRE) && !sysCtrl) begin
            verdict = `NO_SYSTEM_CONTROL_CODE;
        end else if ((funcId == `F_CMD || funcId == `F_GTS) && !cic) begin
            verdict = `NOT_IN_CHARGE_CODE;
        end else if (isIo && !cic && !(funcId == `F_WRITE ? talk : listen)) begin
            verdict = `NOT_ADDRESSED_CODE;
        end else if (funcId == `F_WRITE && !listeners) begin
            verdict = `NO_LISTENER_CODE;
        end else if (funcId == `F_GTS && shadowReq && !atn) begin
            verdict = `NOT_ADDRESSED_CODE;
        end
    end

    // ************************************
    // message sequencer
    // ************************************
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state    <= IDLE;
            pendCode <= `NO_BUS_FAULT_CODE;
            ioStart  <= 1'b0;
            ioWrite  <= 1'b0;
            ioCancel <= 1'b0;
        end else begin
            ioStart  <= 1'b0;
            ioCancel <= 1'b0;
            unique case (state)
                IDLE: begin
                    if (launch) begin
                        state <= EXEC;
                    end
                end
                EXEC: begin
                    pendCode <= verdict;
                    if (verdict == `NO_BUS_FAULT_CODE && isIo) begin
                        ioStart <= 1'b1;
                        ioWrite <= funcId == `F_WRITE;
                        state   <= XFER;
                    end else begin
                        state <= POST;
                    end
                end
                XFER: begin
                    if (ioDone) begin
                        pendCode <= `NO_BUS_FAULT_CODE;
                        state    <= POST;
                    end else if (ioWrite && !cic && atn) begin
                        pendCode <= `NO_LISTENER_CODE;
                        ioCancel <= 1'b1;
                        state    <= POST;
                    end else if (ioAbort || timedOut) begin
                        pendCode <= `IO_ABORTED_CODE;
                        ioCancel <= 1'b1;
                        state    <= POST;
                    end
                end
                POST: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // timeout runs in 10 us units while a transfer is open
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tickCnt  <= 16'h0000;
            unitCnt  <= 32'h0000_0000;
            timedOut <= 1'b0;
        end else if (state != XFER) begin
            tickCnt  <= 16'h0000;
            unitCnt  <= 32'h0000_0000;
            timedOut <= 1'b0;
        end else begin
            timedOut <= unitCnt >= tmoReg;
            if (tickCnt == 16'(TICK_CYCLES - 1)) begin
                tickCnt <= 16'h0000;
                unitCnt <= unitCnt + 32'd1;
            end else begin
                tickCnt <= tickCnt + 16'h0001;
            end
        end
    end

    // ************************************
    // configuration and actions
    // ************************************
    // besides a REG_CONFIG write, only a clean verdict changes settings, so a bad message leaves no trace
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfgMode <= `CFG_MODE_RESET;
            sysCtrl <= `CFG_SC_RESET;
            tmoReg  <= `TMO_RESET;
            ownAddr <= 5'h00;
        end else if (apbWrite && paddr == `REG_CONFIG) begin
            cfgMode <= pwdata[`CFG_MODE_BIT];
            sysCtrl <= pwdata[`CFG_SC_BIT];
        end else if (state == EXEC && verdict == `NO_BUS_FAULT_CODE) begin
            if (funcId == `F_TMO) begin
                tmoReg <= arg0;
            end
            if (funcId == `F_CADDR) begin
                ownAddr <= arg0[4:0];
            end
            if (funcId == `F_RSC) begin
                sysCtrl <= arg0[0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ifcStart    <= 1'b0;
            renOn       <= 1'b0;
            shadowStart <= 1'b0;
        end else begin
            ifcStart    <= state == EXEC && verdict == `NO_BUS_FAULT_CODE && funcId == `F_SIC;
            shadowStart <= state == EXEC && verdict == `NO_BUS_FAULT_CODE
                           && funcId == `F_GTS && shadowReq;
            if (state == EXEC && verdict == `NO_BUS_FAULT_CODE && funcId == `F_SRE) begin
                renOn <= arg0[0];
            end
        end
    end

    // ************************************
    // outcome posting
    // ************************************
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busCode      <= `NO_BUS_FAULT_CODE;
            serialPosted <= 3'h0;
            failFlag     <= 1'b0;
        end else if (state == POST) begin
            busCode      <= pendCode;
            serialPosted <= serialCode;
            failFlag     <= pendCode != `NO_BUS_FAULT_CODE || serialCode != 3'h0;
        end
    end

    // ************************************
    // assertions
    // ************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_fail_has_code;
        failFlag |-> (busCode != `NO_BUS_FAULT_CODE || serialPosted != 3'h0);
    endproperty
    a_fail_has_code: assert property (p_fail_has_code) else $error("flag without code");

    property p_flag_follows;
        state == POST |=> failFlag == ($past(pendCode) != 5'h00 || $past(serialCode) != 3'h0);
    endproperty
    a_flag_follows: assert property (p_flag_follows) else $error("flag wrong after post");

    property p_clean_zero;
        state == POST && pendCode == 5'h00 |=> busCode == 5'h00 && failFlag == (serialPosted != 3'h0);
    endproperty
    a_clean_zero: assert property (p_clean_zero) else $error("clean message left code");

    property p_no_cic;
        state == EXEC && funcId == `F_CMD && !cic && !modeWrong |-> ##2 busCode == 5'h01;
    endproperty
    a_no_cic: assert property (p_no_cic) else $error("missing code 1");

    property p_atn_write;
        state == XFER && ioWrite && !cic && atn && !ioDone |=> ioCancel ##1 busCode == 5'h02;
    endproperty
    a_atn_write: assert property (p_atn_write) else $error("missing code 2 on atn");

    property p_gts_no_shadow;
        state == EXEC && funcId == `F_GTS && shadowReq && !atn |=> !shadowStart;
    endproperty
    a_gts_no_shadow: assert property (p_gts_no_shadow) else $error("shadow started");

    property p_bad_arg;
        state == EXEC && known && !modeWrong && chk.argBad |=> state == POST ##1 busCode == 5'h04;
    endproperty
    a_bad_arg: assert property (p_bad_arg) else $error("missing code 4");

    property p_abort;
        state == XFER && !ioDone && ioAbort && !(ioWrite && !cic && atn) |=> ioCancel ##1 busCode == 5'h06;
    endproperty
    a_abort: assert property (p_abort) else $error("missing code 6");

    property p_hold_code;
        state != POST |=> $stable(busCode);
    endproperty
    a_hold_code: assert property (p_hold_code) else $error("code changed mid message");
endmodule
`default_nettype wire

// ### core/bus_error_map.svh
// bus error code reporter: offsets, fields, codes and timing counts
// assumes a 100 MHz ref_clk and 32-bit APB data
`ifndef BUS_ERROR_MAP_SVH
`define BUS_ERROR_MAP_SVH

// register byte offsets
`define REG_FUNC           8'h00
`define REG_ARG0           8'h04
`define REG_ARG1           8'h08
`define REG_CONFIG         8'h0C
`define REG_STATUS         8'h10
`define REG_ERROR          8'h14

// field positions
`define FUNC_SHADOW_BIT    8
`define CFG_MODE_BIT       0
`define CFG_SC_BIT         1
`define CFG_ADDR_LSB       8
`define STAT_BUSY_BIT      16
`define STAT_FAIL_BIT      15
`define STAT_CMPL_BIT      8
`define STAT_CIC_BIT       5
`define STAT_ATN_BIT       4
`define STAT_TALK_BIT      3
`define STAT_LISTEN_BIT    2
`define ERR_SERIAL_LSB     8

// reset values
`define CFG_MODE_RESET     1'b0
`define CFG_SC_RESET       1'b1
`define TMO_RESET          32'd1000000

// bus error codes
`define NO_BUS_FAULT_CODE      5'h00
`define NOT_IN_CHARGE_CODE     5'h01
`define NO_LISTENER_CODE       5'h02
`define NOT_ADDRESSED_CODE     5'h03
`define BAD_ARGUMENT_CODE      5'h04
`define NO_SYSTEM_CONTROL_CODE 5'h05
`define IO_ABORTED_CODE        5'h06
`define WRONG_MODE_CODE        5'h0B
`define UNKNOWN_FUNCTION_CODE  5'h11

// function identifiers
`define F_WRITE            5'h01
`define F_READ             5'h02
`define F_CMD              5'h03
`define F_GTS              5'h04
`define F_TMO              5'h05
`define F_SIC              5'h06
`define F_SRE              5'h07
`define F_EOS              5'h08
`define F_CADDR            5'h09
`define F_PPC              5'h0A
`define F_RSC              5'h0B
`define F_GSTAT            5'h10

// argument limits, time arguments in 10 us units
`define ARG_UNIT_NS        10000
`define CLK_PERIOD_NS      10
`define TICK_CYCLES        (`ARG_UNIT_NS / `CLK_PERIOD_NS)
`define TMO_MIN            32'd1
`define TMO_MAX            32'd360000000
`define IFC_MIN            32'd10
`define IFC_MAX            32'd360000000
`define BAD_ADDR           32'd31
`define EOS_METHOD_MAX     32'd7
`define BYTE_MAX           32'd255
`define PPC_TOP_BITS       3'h3

`endif

// ### core/bus_error_pkg.sv
// bus error code reporter: shared types
// assumes bus_error_map.svh for the numeric values
package bus_error_pkg;
    typedef enum logic [3:0] {
        IDLE = 4'b0001,
        EXEC = 4'b0010,
        XFER = 4'b0100,
        POST = 4'b1000
    } state_e;
    typedef logic [4:0] code_t;
    typedef logic [4:0] func_t;
endpackage

// ### core/arg_check_if.sv
// carrier between the reporter and its argument checker
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface arg_check_if import bus_error_pkg::*;;
    func_t       funcId;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic        argBad;
    modport reporter (output funcId, output arg0, output arg1, input argBad);
    modport judge (input funcId, input arg0, input arg1, output argBad);
endinterface
`default_nettype wire

// ### core/arg_range_checker.sv
// argument validity check for one programming message
// assumes stable arguments while the reporter evaluates them
`timescale 1ns/1ps
`default_nettype none
`include "bus_error_map.svh"
module arg_range_checker import bus_error_pkg::*; (
    // message under test
    arg_check_if.judge chk
);
    // any bad argument flags the whole message
    always_comb begin
        chk.argBad = 1'b0;
        unique case (chk.funcId)
            `F_TMO: begin
                chk.argBad = (chk.arg0 < `TMO_MIN) || (chk.arg0 > `TMO_MAX);
            end
            `F_SIC: begin
                chk.argBad = (chk.arg0 < `IFC_MIN) || (chk.arg0 > `IFC_MAX);
            end
            `F_EOS: begin
                chk.argBad = (chk.arg0 > `BYTE_MAX) || (chk.arg1 > `EOS_METHOD_MAX);
            end
            `F_CADDR: begin
                chk.argBad = (chk.arg0 >= `BAD_ADDR);
            end
            `F_PPC: begin
                chk.argBad = (chk.arg0 > `BYTE_MAX) || (chk.arg0[7:5] != `PPC_TOP_BITS);
            end
            default: begin
                chk.argBad = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ### verif/xfer_engine_model.sv
// transfer engine stand-in: answers ioStart with done, abort or silence
// assumes the reporter's ref_clk and reset
`timescale 1ns/1ps
`default_nettype none
module xfer_engine_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // handshake with the reporter
    input  wire logic       ioStart,
    input  wire logic       ioCancel,
    input  wire logic [1:0] engMode,
    output logic            ioDone,
    output logic            ioAbort
);
    // ************
    // engine timing
    // ************
    logic [5:0] left;
    // mode 0 quick done, 1 abort, 2 silent so timeout decides, 3 slow done
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            left <= 6'h00;
        end else if (ioStart) begin
            left <= (engMode == 2'h3) ? 6'h28 : 6'h04;
        end else if (ioCancel || left == 6'h01) begin
            left <= 6'h00;
        end else if (left != 6'h00 && engMode != 2'h2) begin
            left <= left - 6'h01;
        end
    end
    assign ioDone  = left == 6'h01 && engMode[0] == 1'b0 || left == 6'h01 && engMode == 2'h3;
    assign ioAbort = left == 6'h01 && engMode == 2'h1;
endmodule
`default_nettype wire

// ### verif/bus_error_code_reporter_tb.sv
// reporter testbench: messages over APB, bus pins driven, engine model
// assumes the map header and a 100 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "bus_error_map.svh"
module bus_error_code_reporter_tb import bus_error_pkg::*;;
    logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, last;
    logic        cicPin, atnPin, talkPin, listenPin, listenersPin;
    logic        ioStart, ioWrite, ioCancel, ioDone, ioAbort;
    logic        ifcStart, renOn, shadowStart, slvErr, sawShadow, sawIfc;
    logic [2:0]  serialCode;
    logic [1:0]  engMode;
    int          n_mismatch, tests_run;
    bus_error_code_reporter #(.TICK_CYCLES(2)) dut_u (
        .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cicPin, .atnPin, .talkPin, .listenPin, .listenersPin, .ioStart,
        .ioWrite, .ioCancel, .ioDone, .ioAbort, .ifcStart, .renOn, .shadowStart, .serialCode
    );
    xfer_engine_model eng_u (
        .ref_clk, .reset, .ioStart, .ioCancel, .engMode, .ioDone, .ioAbort
    );
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (shadowStart === 1'b1) sawShadow <= 1'b1;
        if (ifcStart === 1'b1) sawIfc <= 1'b1;
    end
    // ************
    // shared tasks
    // ************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // request held from setup until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        slvErr = pslverr;
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic launch(input logic [31:0] f, input logic [31:0] a0, input logic [31:0] a1);
        logic [31:0] r;
        apb(1'b1, `REG_ARG0, a0, r);
        apb(1'b1, `REG_ARG1, a1, r);
        apb(1'b1, `REG_FUNC, f, r);
    endtask
    task automatic finish(input code_t exp);
        logic [31:0] st;
        int n;
        n = 0;
        st = 32'h0001_0000;
        while (st[`STAT_BUSY_BIT] !== 1'b0 && n < 300) begin
            apb(1'b0, `REG_STATUS, 32'h0, st);
            n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            report_and_stop();
        end
        apb(1'b0, `REG_ERROR, 32'h0, last);
        chk(32'(last[4:0]), 32'(exp));
        chk(32'(st[`STAT_FAIL_BIT]), 32'(exp != 0 || serialCode != 0));
    endtask
    task automatic run(input logic [31:0] f, input logic [31:0] a0, input code_t exp);
        launch(f, a0, 32'h0);
        finish(exp);
    endtask
    // ************
    // scenarios
    // ************
    task automatic s_reset_and_refuse();
        logic [31:0] r;
        apb(1'b0, `REG_CONFIG, 32'h0, r);
        chk(r, 32'h0000_0002);
        apb(1'b0, `REG_ERROR, 32'h0, r);
        chk(r, 32'h0);
        apb(1'b1, `REG_ERROR, 32'h0000_0011, r);
        chk(32'(slvErr), 32'h1);
        apb(1'b0, 8'hFC, 32'h0, r);
        chk(32'(slvErr), 32'h1);
    endtask
    task automatic s_bad_messages();
        logic [31:0] r;
        run(32'h1F, 32'h0, `UNKNOWN_FUNCTION_CODE);
        run(`F_GSTAT, 32'h0, `WRONG_MODE_CODE);
        run(`F_TMO, 32'h0, `BAD_ARGUMENT_CODE);
        run(`F_TMO, 32'd360000001, `BAD_ARGUMENT_CODE);
        run(`F_SIC, 32'd9, `BAD_ARGUMENT_CODE);
        run(`F_CADDR, 32'd31, `BAD_ARGUMENT_CODE);
        apb(1'b0, `REG_CONFIG, 32'h0, r);
        chk(r, 32'h0000_0002);
        run(`F_CADDR, 32'd30, `NO_BUS_FAULT_CODE);
        apb(1'b0, `REG_CONFIG, 32'h0, r);
        chk(r, 32'h0000_1E02);
        run(`F_PPC, 32'h60, `NO_BUS_FAULT_CODE);
        run(`F_PPC, 32'hFF, `BAD_ARGUMENT_CODE);
        launch(`F_EOS, 32'h0A, 32'h8);
        finish(`BAD_ARGUMENT_CODE);
    endtask
    task automatic s_system_control();
        run(`F_RSC, 32'h0, `NO_BUS_FAULT_CODE);
        run(`F_SIC, 32'd100, `NO_SYSTEM_CONTROL_CODE);
        run(`F_SRE, 32'h1, `NO_SYSTEM_CONTROL_CODE);
        chk(32'(renOn), 32'h0);
        run(`F_RSC, 32'h1, `NO_BUS_FAULT_CODE);
        sawIfc = 1'b0;
        run(`F_SIC, 32'd10, `NO_BUS_FAULT_CODE);
        chk(32'(sawIfc), 32'h1);
        run(`F_SRE, 32'h1, `NO_BUS_FAULT_CODE);
        chk(32'(renOn), 32'h1);
    endtask
    task automatic s_not_in_charge();
        cicPin <= 1'b0;
        run(`F_CMD, 32'h1, `NOT_IN_CHARGE_CODE);
        run(`F_GTS, 32'h0, `NOT_IN_CHARGE_CODE);
        run(`F_WRITE, 32'h1, `NOT_ADDRESSED_CODE);
        run(`F_READ, 32'h1, `NOT_ADDRESSED_CODE);
        talkPin <= 1'b1;
        engMode <= 2'h3;
        launch(`F_WRITE, 32'h1, 32'h0);
        repeat (8) @(posedge ref_clk);
        atnPin <= 1'b1;
        finish(`NO_LISTENER_CODE);
        chk(32'(ioWrite), 32'h1);
        atnPin <= 1'b0;
        talkPin <= 1'b0;
        cicPin <= 1'b1;
    endtask
    task automatic s_transfers();
        logic [31:0] r;
        listenersPin <= 1'b0;
        run(`F_WRITE, 32'h1, `NO_LISTENER_CODE);
        listenersPin <= 1'b1;
        engMode <= 2'h0;
        run(`F_WRITE, 32'h1, `NO_BUS_FAULT_CODE);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, `REG_ERROR, 32'h0, r);
        chk(r, last);
        engMode <= 2'h1;
        run(`F_WRITE, 32'h1, `IO_ABORTED_CODE);
        engMode <= 2'h0;
        run(`F_READ, 32'h1, `NO_BUS_FAULT_CODE);
        chk(32'(ioWrite), 32'h0);
    endtask
    task automatic s_standby();
        logic [31:0] r;
        apb(1'b0, `REG_STATUS, 32'h0, r);
        chk(32'(r[`STAT_CIC_BIT]), 32'h1);
        run(`F_CMD, 32'h1, `NO_BUS_FAULT_CODE);
        sawShadow = 1'b0;
        run(32'h100 | `F_GTS, 32'h0, `NOT_ADDRESSED_CODE);
        chk(32'(sawShadow), 32'h0);
        atnPin <= 1'b1;
        run(32'h100 | `F_GTS, 32'h0, `NO_BUS_FAULT_CODE);
        chk(32'(sawShadow), 32'h1);
        atnPin <= 1'b0;
    endtask
    task automatic s_serial_and_mode();
        logic [31:0] r;
        apb(1'b1, `REG_CONFIG, 32'h3, r);
        serialCode <= 3'h5;
        run(`F_GSTAT, 32'h0, `NO_BUS_FAULT_CODE);
        chk(32'(last[10:8]), 32'h5);
        serialCode <= 3'h0;
        run(`F_WRITE, 32'h1, `WRONG_MODE_CODE);
        apb(1'b1, `REG_CONFIG, 32'h2, r);
        run(`F_TMO, 32'd3, `NO_BUS_FAULT_CODE);
        engMode <= 2'h2;
        run(`F_WRITE, 32'h1, `IO_ABORTED_CODE);
    endtask
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        {reset, sawShadow, sawIfc} = 3'b100;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cicPin, atnPin, talkPin, listenPin, listenersPin} = 5'b10001;
        engMode = 2'h0;
        serialCode = 3'h0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        s_reset_and_refuse();
        s_bad_messages();
        s_system_control();
        s_not_in_charge();
        s_transfers();
        s_standby();
        s_serial_and_mode();
        report_and_stop();
    end
endmodule
`default_nettype wire
